// ==== hdl/pwrseq_pkg.sv ====
// Purpose: Constants for the boot-control power sequencer
// Assumes: 200 MHz system clock
// Notes:   Slot numbers 0 mean unassigned
package pwrseq_pkg;
  localparam int          CLK_MHZ          = 200;
  localparam int          SLOT_SHORT_US    = 500;
  localparam int          SLOT_LONG_US     = 2000;
  localparam int          SLOT_SHORT_CYC   = SLOT_SHORT_US * CLK_MHZ;
  localparam int          SLOT_LONG_CYC    = SLOT_LONG_US * CLK_MHZ;
  localparam int          WDOG_PERIOD_S    = 100;
  localparam longint      WDOG_CYC         = longint'(WDOG_PERIOD_S) * 64'd1000000 * longint'(CLK_MHZ);
  localparam int          NUM_SLOTS        = 15;
  localparam logic [3:0]  SLOT_CORE_A      = 4'h3;
  localparam logic [3:0]  SLOT_CORE_B      = 4'h6;
  localparam logic [3:0]  SLOT_IO          = 4'h4;
  localparam logic [3:0]  SLOT_EXT_FET     = 4'h0;
  localparam logic [3:0]  SLOT_GPO0        = 4'h1;
  localparam logic [3:0]  SLOT_GPO2        = 4'h0;
  localparam logic [3:0]  SLOT_GPO6        = 4'h6;
  localparam logic [3:0]  SLOT_GPO7        = 4'h5;
  localparam logic [3:0]  SLOT_CLKOUT      = 4'h5;
  localparam logic [3:0]  SLOT_RESET       = 4'ha;
  // Voltage codes in 100 mV units
  localparam logic [4:0]  VSEL_CORE_A      = 5'h0c;
  localparam logic [4:0]  VSEL_CORE_B      = 5'h0f;
  localparam logic [4:0]  VSEL_IO          = 5'h12;
  localparam logic        RST_BKUP_OFFMASK = 1'b0;
  localparam logic        RST_CLK_SRC      = 1'b0;
  localparam logic        RST_KEEP_ON      = 1'b0;
  localparam logic        RST_SLOT_DUR     = 1'b1;
  localparam logic        RST_LP_OFF       = 1'b1;
  localparam logic        RST_LP_RST       = 1'b1;
  localparam logic        RST_IRQ_POL      = 1'b0;
  localparam logic        RST_SUPPLY_MSK   = 1'b1;
  localparam logic        RST_FALL_MSK     = 1'b1;
  localparam logic        RST_RISE_MSK     = 1'b0;
  localparam logic        RST_WDOG_FIXED   = 1'b1;
  localparam logic        RST_WDOG_MEM     = 1'b0;
  localparam logic        RST_AUTO_KEEP    = 1'b0;
  localparam logic        RST_SHDN_POL     = 1'b0;
  localparam logic [7:0]  RST_SLEEP_KEEP   = 8'h00;
  // Register offsets
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_MASK         = 4'h1;
  localparam logic [3:0]  REG_SLEEP_KEEP   = 4'h2;
  localparam logic [3:0]  REG_STATUS       = 4'h3;
  localparam logic [3:0]  REG_VSEL         = 4'h4;
  // Control register field positions
  localparam int          CB_BKUP = 0;
  localparam int          CB_CLK  = 1;
  localparam int          CB_KEEP = 2;
  localparam int          CB_SLOT = 3;
  localparam int          CB_LPO  = 4;
  localparam int          CB_LPR  = 5;
  localparam int          CB_IPOL = 6;
  localparam int          CB_WDOG = 7;
  localparam int          CB_REV  = 8;
  localparam int          CB_SPOL = 9;
  localparam int          CB_SLEN = 10;
  localparam int          CB_SLPP = 11;
  // Sleep keep bit per resource
  localparam int          KB_CORE_A = 0;
  localparam int          KB_CORE_B = 1;
  localparam int          KB_IO     = 2;
  localparam int          KB_FET    = 3;
  localparam int          KB_CLK    = 4;
  typedef enum logic [3:0] {
    PWRSEQ_OFF   = 4'h1,
    PWRSEQ_UP    = 4'h2,
    PWRSEQ_ACT   = 4'h4,
    PWRSEQ_DOWN  = 4'h8
  } pwrseq_state_type;
endpackage : pwrseq_pkg

// ==== hdl/pwrseq_top.sv ====
// Purpose: Boot configuration and OFF/ACTIVE/SLEEP sequencing
// Assumes: Pins are asynchronous, host uses plain register port
// Notes:   Sleep is a flag inside ACTIVE
// Operation
// - Core A slot 3, B slot 6, io 4
// - Pin slots 1,0,6,5, reset slot 10
// - Boot voltages 1.2, 1.5, 1.8 V
// - Backup off-mask defaults to zero
// - Clock source select defaults crystal
// - Keep-on bit holds device on
// - Slot duration 0.5 or 2 ms
// - Long press turns off when enabled
// - Long press resets core when both reset and long-press off are enabled
// - Interrupt polarity select, default low
// - Supply-rise mask default set, autostart
// - Pin 4/5 fall masked, rise unmasked
// - Watchdog 100 s, default per boot
// - Auto keep-on makes hold plain input
// - Shutdown input polarity, default low
// - Sleep input edges enter/leave sleep
// - Sleep drops resources unless kept
// - General outputs except gpo2 follow sleep input
// - Hold level moves OFF to ACTIVE
// - Hold edges raise maskable interrupt
// - Reset release sets keep-on automatically
// - Boot select sampled, no debounce
// - Boot select floating, 0, 1 modes
// - Fifteen slots, optional reverse off
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module pwrseq_top #(
  parameter int          SLOT_SHORT = pwrseq_pkg::SLOT_SHORT_CYC,
  parameter int          SLOT_LONG  = pwrseq_pkg::SLOT_LONG_CYC,
  parameter longint      WDOG_LEN   = pwrseq_pkg::WDOG_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        boot_select_pin,
  input  wire logic        boot_select_oe_n,
  input  wire logic        sleep_pin,
  input  wire logic        hold_input,
  input  wire logic        shutdown_input,
  input  wire logic        long_press,
  input  wire logic        supply_rise,
  input  wire logic        pin4_in,
  input  wire logic        pin5_in,
  output logic             boot_pad_en,
  output logic             core_converter_a,
  output logic             core_converter_b,
  output logic             io_converter,
  output logic             external_fet_controller,
  output logic             core_a_lowpower,
  output logic             core_b_lowpower,
  output logic             io_lowpower,
  output logic             slow_clock_output_en,
  output logic             gpo0,
  output logic             gpo2,
  output logic             gpo6,
  output logic             gpo7,
  output logic             gpo8,
  output logic             processor_reset_out,
  output logic             second_reset_out,
  output logic             irq_output,
  output logic             core_reset,
  output logic             watchdog_tick,
  output logic [14:0]      voltage_sel
);
  // ==========================================
  // Synchronisers
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
    end else if (clk_en) begin
      s1_r <= {boot_select_oe_n, boot_select_pin, pin5_in, pin4_in, supply_rise, long_press, shutdown_input,
               hold_input};
      s2_r <= s1_r;
    end
  end
  logic hold_s, shdn_s, lp_s, sup_s, p4_s, p5_s, boot_s, float_s, slp_s1_r, slp_s;
  assign hold_s  = s2_r[0];
  assign shdn_s  = s2_r[1];
  assign lp_s    = s2_r[2];
  assign sup_s   = s2_r[3];
  assign p4_s    = s2_r[4];
  assign p5_s    = s2_r[5];
  assign boot_s  = s2_r[6];
  assign float_s = s2_r[7];
  logic slp_s2_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slp_s1_r <= 1'b1;
      slp_s2_r <= 1'b1;
    end else if (clk_en) begin
      slp_s1_r <= sleep_pin;
      slp_s2_r <= slp_s1_r;
    end
  end
  assign slp_s = slp_s2_r;

  // ==========================================
  // Boot mode capture
  logic        boot_done_r;
  logic [1:0]  boot_wait_r;
  logic        mem_boot_r;
  logic        test_boot_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boot_done_r <= 1'b0;
      boot_wait_r <= 2'h0;
      mem_boot_r  <= 1'b0;
      test_boot_r <= 1'b0;
      boot_pad_en <= 1'b1;
    end else if (clk_en && !boot_done_r) begin
      boot_wait_r <= boot_wait_r + 2'h1;
      if (boot_wait_r == 2'h3) begin
        boot_done_r <= 1'b1;
        mem_boot_r  <= boot_s;
        test_boot_r <= float_s;
        boot_pad_en <= 1'b0;
      end
    end
  end

  // ==========================================
  // Registers
  logic [11:0] ctrl_r;
  logic [5:0]  mask_r;
  logic [7:0]  keep_r;
  logic        auto_keep_r;
  logic        keep_set;
  logic        wr_ctrl;
  assign wr_ctrl = clk_en && reg_wr && reg_addr == pwrseq_pkg::REG_CTRL;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= {1'b0, 1'b0, pwrseq_pkg::RST_SHDN_POL, 1'b0, pwrseq_pkg::RST_WDOG_FIXED,
                 pwrseq_pkg::RST_IRQ_POL, pwrseq_pkg::RST_LP_RST, pwrseq_pkg::RST_LP_OFF,
                 pwrseq_pkg::RST_SLOT_DUR, pwrseq_pkg::RST_KEEP_ON, pwrseq_pkg::RST_CLK_SRC,
                 pwrseq_pkg::RST_BKUP_OFFMASK};
    end else if (clk_en) begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata[11:0];
      if (!boot_done_r && boot_wait_r == 2'h3 && boot_s)
        ctrl_r[pwrseq_pkg::CB_WDOG] <= pwrseq_pkg::RST_WDOG_MEM;
      if (keep_set)
        ctrl_r[pwrseq_pkg::CB_KEEP] <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_r <= {pwrseq_pkg::RST_RISE_MSK, pwrseq_pkg::RST_FALL_MSK, pwrseq_pkg::RST_RISE_MSK,
                 pwrseq_pkg::RST_FALL_MSK, pwrseq_pkg::RST_SUPPLY_MSK, 1'b0};
      keep_r <= pwrseq_pkg::RST_SLEEP_KEEP;
      auto_keep_r <= pwrseq_pkg::RST_AUTO_KEEP;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == pwrseq_pkg::REG_MASK)
        mask_r <= reg_wdata[5:0];
      if (reg_addr == pwrseq_pkg::REG_SLEEP_KEEP)
        keep_r <= reg_wdata[7:0];
      if (reg_addr == pwrseq_pkg::REG_STATUS)
        auto_keep_r <= reg_wdata[15];
    end
  end

  // ==========================================
  // Sequencer
  pwrseq_pkg::pwrseq_state_type st_r;
  logic [3:0]  slot_r;
  logic [31:0] tick_r;
  logic        tick;
  logic        sleep_r;
  logic        auto_on_r;
  logic        shdn_act, on_req, off_req, hold_mode, slot_end;
  assign hold_mode = !auto_keep_r;
  assign shdn_act  = shdn_s ^ !ctrl_r[pwrseq_pkg::CB_SPOL];
  assign off_req   = shdn_act || (lp_s && ctrl_r[pwrseq_pkg::CB_LPO]);
  assign on_req    = !off_req && ((hold_mode && hold_s) || ctrl_r[pwrseq_pkg::CB_KEEP] ||
                     auto_on_r);
  assign slot_end  = ctrl_r[pwrseq_pkg::CB_SLOT] ? (tick_r == 32'(SLOT_LONG - 1)) :
                     (tick_r == 32'(SLOT_SHORT - 1));
  assign tick      = slot_end;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      auto_on_r <= 1'b0;
    else if (clk_en)
      auto_on_r <= (sup_s && !mask_r[1]) ? 1'b1 : (st_r == pwrseq_pkg::PWRSEQ_ACT ? 1'b0 : auto_on_r);
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r   <= pwrseq_pkg::PWRSEQ_OFF;
      slot_r <= 4'h0;
      tick_r <= 32'h0;
    end else if (clk_en && boot_done_r) begin
      tick_r <= (st_r == pwrseq_pkg::PWRSEQ_UP || st_r == pwrseq_pkg::PWRSEQ_DOWN) && !slot_end ?
                tick_r + 32'h1 : 32'h0;
      case (st_r)
        pwrseq_pkg::PWRSEQ_OFF: begin
          slot_r <= 4'h0;
          if (on_req)
            st_r <= pwrseq_pkg::PWRSEQ_UP;
        end
        pwrseq_pkg::PWRSEQ_UP: begin
          if (!on_req) begin
            st_r <= ctrl_r[pwrseq_pkg::CB_REV] ? pwrseq_pkg::PWRSEQ_DOWN : pwrseq_pkg::PWRSEQ_OFF;
          end else if (tick) begin
            if (slot_r == 4'(pwrseq_pkg::NUM_SLOTS))
              st_r <= pwrseq_pkg::PWRSEQ_ACT;
            else
              slot_r <= slot_r + 4'h1;
          end
        end
        pwrseq_pkg::PWRSEQ_ACT: begin
          if (!on_req) begin
            if (ctrl_r[pwrseq_pkg::CB_REV])
              st_r <= pwrseq_pkg::PWRSEQ_DOWN;
            else begin
              st_r   <= pwrseq_pkg::PWRSEQ_OFF;
              slot_r <= 4'h0;
            end
          end
        end
        pwrseq_pkg::PWRSEQ_DOWN: begin
          if (tick) begin
            if (slot_r == 4'h0)
              st_r <= pwrseq_pkg::PWRSEQ_OFF;
            else
              slot_r <= slot_r - 4'h1;
          end
        end
        default: st_r <= pwrseq_pkg::PWRSEQ_OFF;
      endcase
    end
  end

  // ==========================================
  // Sleep control
  logic slp_act, slp_prev_r;
  logic irq_act;
  assign slp_act = slp_s ^ !ctrl_r[pwrseq_pkg::CB_SLPP];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sleep_r    <= 1'b0;
      slp_prev_r <= 1'b0;
    end else if (clk_en) begin
      slp_prev_r <= slp_act;
      if (st_r != pwrseq_pkg::PWRSEQ_ACT)
        sleep_r <= 1'b0;
      else if (slp_act && !slp_prev_r && ctrl_r[pwrseq_pkg::CB_SLEN] && !irq_act)
        sleep_r <= 1'b1;
      else if (!slp_act && slp_prev_r)
        sleep_r <= 1'b0;
    end
  end

  // ==========================================
  // Outputs
  logic on_a, on_b, on_io, on_fet, on_clk, on_g0, on_g2, on_g6, on_g7, on_rst, live;
  logic rst_prev_r;
  assign live   = st_r != pwrseq_pkg::PWRSEQ_OFF;
  assign on_a   = live && pwrseq_pkg::SLOT_CORE_A  != 4'h0 && slot_r >= pwrseq_pkg::SLOT_CORE_A;
  assign on_b   = live && pwrseq_pkg::SLOT_CORE_B  != 4'h0 && slot_r >= pwrseq_pkg::SLOT_CORE_B;
  assign on_io  = live && pwrseq_pkg::SLOT_IO      != 4'h0 && slot_r >= pwrseq_pkg::SLOT_IO;
  assign on_fet = live && pwrseq_pkg::SLOT_EXT_FET != 4'h0 && slot_r >= pwrseq_pkg::SLOT_EXT_FET;
  assign on_clk = live && pwrseq_pkg::SLOT_CLKOUT  != 4'h0 && slot_r >= pwrseq_pkg::SLOT_CLKOUT;
  assign on_g0  = live && pwrseq_pkg::SLOT_GPO0    != 4'h0 && slot_r >= pwrseq_pkg::SLOT_GPO0;
  assign on_g2  = live && pwrseq_pkg::SLOT_GPO2    != 4'h0 && slot_r >= pwrseq_pkg::SLOT_GPO2;
  assign on_g6  = live && pwrseq_pkg::SLOT_GPO6    != 4'h0 && slot_r >= pwrseq_pkg::SLOT_GPO6;
  assign on_g7  = live && pwrseq_pkg::SLOT_GPO7    != 4'h0 && slot_r >= pwrseq_pkg::SLOT_GPO7;
  assign on_rst = live && slot_r >= pwrseq_pkg::SLOT_RESET && st_r != pwrseq_pkg::PWRSEQ_DOWN;
  assign keep_set = auto_keep_r && on_rst && !rst_prev_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_converter_a        <= 1'b0;
      core_converter_b        <= 1'b0;
      io_converter            <= 1'b0;
      external_fet_controller <= 1'b0;
      core_a_lowpower         <= 1'b0;
      core_b_lowpower         <= 1'b0;
      io_lowpower             <= 1'b0;
      slow_clock_output_en    <= 1'b0;
      gpo0                    <= 1'b0;
      gpo2                    <= 1'b0;
      gpo6                    <= 1'b0;
      gpo7                    <= 1'b0;
      gpo8                    <= 1'b0;
      processor_reset_out     <= 1'b0;
      second_reset_out        <= 1'b0;
      rst_prev_r              <= 1'b0;
      voltage_sel             <= 15'h0;
    end else if (clk_en) begin
      core_converter_a        <= on_a;
      core_converter_b        <= on_b;
      io_converter            <= on_io;
      external_fet_controller <= on_fet && !(sleep_r && !keep_r[pwrseq_pkg::KB_FET]);
      core_a_lowpower         <= sleep_r && !keep_r[pwrseq_pkg::KB_CORE_A];
      core_b_lowpower         <= sleep_r && !keep_r[pwrseq_pkg::KB_CORE_B];
      io_lowpower             <= sleep_r && !keep_r[pwrseq_pkg::KB_IO];
      slow_clock_output_en    <= on_clk && !(sleep_r && !keep_r[pwrseq_pkg::KB_CLK]);
      gpo0                    <= on_g0 && !sleep_r;
      gpo2                    <= on_g2;
      gpo6                    <= on_g6 && !sleep_r;
      gpo7                    <= on_g7 && !sleep_r;
      gpo8                    <= live && !sleep_r;
      processor_reset_out     <= on_rst;
      second_reset_out        <= on_rst;
      rst_prev_r              <= on_rst;
      voltage_sel             <= {pwrseq_pkg::VSEL_IO, pwrseq_pkg::VSEL_CORE_B, pwrseq_pkg::VSEL_CORE_A};
    end
  end

  // ==========================================
  // Interrupts, long press reset, watchdog
  logic [4:0]  irq_stat_r;
  logic        hold_prev_r, p4_prev_r, p5_prev_r, lp_prev_r;
  logic [4:0]  irq_set;
  logic [63:0] wd_r;
  assign irq_set = {p5_s && !p5_prev_r && !mask_r[5], !p5_s && p5_prev_r && !mask_r[4],
                    p4_s && !p4_prev_r && !mask_r[3], !p4_s && p4_prev_r && !mask_r[2],
                    hold_s != hold_prev_r && !mask_r[0]};
  assign irq_act = |irq_stat_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r  <= 5'h0;
      hold_prev_r <= 1'b0;
      p4_prev_r   <= 1'b0;
      p5_prev_r   <= 1'b0;
      lp_prev_r   <= 1'b0;
      irq_output  <= 1'b1;
      core_reset  <= 1'b0;
      wd_r        <= 64'h0;
      watchdog_tick <= 1'b0;
      reg_rdata   <= 16'h0;
    end else if (clk_en) begin
      hold_prev_r <= hold_s;
      p4_prev_r   <= p4_s;
      p5_prev_r   <= p5_s;
      lp_prev_r   <= lp_s;
      if (reg_wr && reg_addr == pwrseq_pkg::REG_STATUS)
        irq_stat_r <= (irq_stat_r & ~reg_wdata[4:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      irq_output  <= irq_act ^ !ctrl_r[pwrseq_pkg::CB_IPOL];
      core_reset  <= lp_s && !lp_prev_r && ctrl_r[pwrseq_pkg::CB_LPR] && ctrl_r[pwrseq_pkg::CB_LPO];
      watchdog_tick <= 1'b0;
      if (!ctrl_r[pwrseq_pkg::CB_WDOG])
        wd_r <= 64'h0;
      else if (wd_r == 64'(WDOG_LEN - 1)) begin
        wd_r <= 64'h0;
        watchdog_tick <= 1'b1;
      end else
        wd_r <= wd_r + 64'h1;
      if (reg_rd) begin
        case (reg_addr)
          pwrseq_pkg::REG_CTRL:       reg_rdata <= {4'h0, ctrl_r};
          pwrseq_pkg::REG_MASK:       reg_rdata <= {10'h0, mask_r};
          pwrseq_pkg::REG_SLEEP_KEEP: reg_rdata <= {8'h0, keep_r};
          pwrseq_pkg::REG_STATUS:     reg_rdata <= {auto_keep_r, test_boot_r, mem_boot_r, sleep_r, st_r, slot_r,
                                                    3'h0, irq_act};
          pwrseq_pkg::REG_VSEL:       reg_rdata <= {1'b0, voltage_sel};
          default:                    reg_rdata <= 16'h0;
        endcase
      end else
        reg_rdata <= 16'h0;
    end
  end

  chk_keep_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && keep_set |=> ctrl_r[pwrseq_pkg::CB_KEEP]) else $error("keep-on not set");
  chk_boot_pad: assert property (@(posedge clk_sys) disable iff (!rstn)
    boot_done_r |-> !boot_pad_en) else $error("boot pad still enabled");
  chk_reset_slot: assert property (@(posedge clk_sys) disable iff (!rstn)
    processor_reset_out |-> core_converter_a && io_converter) else $error("reset before supplies");
  chk_sleep_gpo: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && sleep_r |=> !gpo0 && !gpo8) else $error("gpo active in sleep");
  chk_irq_pol: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && !irq_act && !ctrl_r[pwrseq_pkg::CB_IPOL] |=> irq_output) else $error("irq idle level");
  chk_slot_max: assert property (@(posedge clk_sys) disable iff (!rstn)
    slot_r <= 4'(pwrseq_pkg::NUM_SLOTS)) else $error("slot overrun");
  chk_shdn_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    clk_en && boot_done_r && shdn_act && st_r == pwrseq_pkg::PWRSEQ_ACT && !ctrl_r[pwrseq_pkg::CB_REV]
    |=> st_r == pwrseq_pkg::PWRSEQ_OFF) else $error("shutdown ignored");
  chk_core_b: assert property (@(posedge clk_sys) disable iff (!rstn)
    core_converter_b |-> core_converter_a) else $error("slot order broken");
endmodule : pwrseq_top

// ==== bench/pwrseq_host.sv ====
// Purpose: Host model driving the hold and sleep levels
// Assumes: Levels change one cycle after a request
// Notes:   No debounce on either line
`timescale 1ns/1ps
module pwrseq_host (
  input  wire logic clk_sys,
  input  wire logic hold_req,
  input  wire logic sleep_req,
  output logic      hold_input,
  output logic      sleep_pin
);
  initial begin
    hold_input = 1'b0;
    sleep_pin  = 1'b1;
  end
  always @(posedge clk_sys) begin
    hold_input <= hold_req;
    sleep_pin  <= sleep_req;
  end
endmodule : pwrseq_host

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the boot-control sequencer
// Assumes: Fixed boot, shortened slot parameters
// Notes:   Host model drives hold and sleep
`timescale 1ns/1ps
module tb;
  localparam int SL = 16;
  localparam int SS = 4;
  localparam int WD = 100;
  logic        clk_sys, rstn, reg_wr, reg_rd, hold_req, sleep_req, lp;
  logic [1:0]  pins;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic        hold_input, sleep_pin, core_a, core_b, io_on, fet, a_lp, b_lp, clk_out, gpo0, gpo2, rst_out, irq;
  logic        supply, shdn, bpad, io_lp, g6, g7, g8, rst2, crst, wdt;
  logic [14:0] vsel;
  int          errors, total_checks, cyc;
  pwrseq_top #(.SLOT_SHORT(SS), .SLOT_LONG(SL), .WDOG_LEN(WD)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_select_pin(1'b0), .boot_select_oe_n(1'b0),
    .sleep_pin(sleep_pin), .hold_input(hold_input), .shutdown_input(shdn), .long_press(lp),
    .supply_rise(supply), .pin4_in(pins[0]), .pin5_in(pins[1]), .boot_pad_en(bpad), .core_converter_a(core_a),
    .core_converter_b(core_b), .io_converter(io_on), .external_fet_controller(fet), .core_a_lowpower(a_lp),
    .core_b_lowpower(b_lp), .io_lowpower(io_lp), .slow_clock_output_en(clk_out), .gpo0(gpo0), .gpo2(gpo2),
    .gpo6(g6), .gpo7(g7), .gpo8(g8), .processor_reset_out(rst_out), .second_reset_out(rst2), .irq_output(irq),
    .core_reset(crst), .watchdog_tick(wdt), .voltage_sel(vsel));
  pwrseq_host i_host (.clk_sys(clk_sys), .hold_req(hold_req), .sleep_req(sleep_req),
    .hold_input(hold_input), .sleep_pin(sleep_pin));
  // ==========================================
  // Shared tasks
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic await(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 3000) begin
      @(posedge clk_sys);
      #1 k++;
    end
    if (k == 3000) check("await", 16'h0, 16'h1);
  endtask : await
  // ==========================================
  // Scenarios
  task automatic t_defaults();
    int k;
    check("boot_pad", {15'h0, bpad}, 16'h0);
    await(wdt, 1'b1, k);
    await(wdt, 1'b0, k);
    await(wdt, 1'b1, k);
    check("wdog", 16'(k), 16'(WD - 1));
    rd(pwrseq_pkg::REG_CTRL);
    check("ctrl", d, 16'h00b8);
    rd(pwrseq_pkg::REG_MASK);
    check("mask", d, 16'h0016);
    rd(4'hf);
    check("unmapped", d, 16'h0000);
  endtask : t_defaults
  task automatic t_power_on(input logic [15:0] ctrl, input int len);
    int k;
    wr(pwrseq_pkg::REG_CTRL, ctrl);
    hold_req <= 1'b1;
    await(core_a, 1'b1, k);
    check("io_early", {15'h0, io_on}, 16'h0);
    await(io_on, 1'b1, k);
    check("slot_a_io", 16'(k), 16'(len));
    await(core_b, 1'b1, k);
    check("slot_io_b", 16'(k), 16'(2 * len));
    await(rst_out, 1'b1, k);
    check("slot_b_rst", 16'(k), 16'(4 * len));
    check("pins", {9'h0, rst2, gpo0, gpo2, g6, g7, fet, clk_out}, 16'h006d);
    check("vsel", {1'b0, vsel}, {1'b0, 5'h12, 5'h0f, 5'h0c});
    check("irq_hold", {15'h0, irq}, 16'h0);
    wr(pwrseq_pkg::REG_STATUS, 16'h001f);
    await(irq, 1'b1, k);
  endtask : t_power_on
  task automatic t_sleep();
    int k;
    repeat (7 * SL) @(posedge clk_sys);
    rd(pwrseq_pkg::REG_STATUS);
    check("state_act", {12'h0, d[11:8]}, 16'(pwrseq_pkg::PWRSEQ_ACT));
    wr(pwrseq_pkg::REG_SLEEP_KEEP, 16'h0001);
    sleep_req <= 1'b0;
    await(b_lp, 1'b1, k);
    check("sleep_kept", {12'h0, a_lp, clk_out, gpo0, g8}, 16'h0);
    check("sleep_io", {15'h0, io_lp}, 16'h1);
    sleep_req <= 1'b1;
    await(b_lp, 1'b0, k);
    check("wake_clk", {15'h0, clk_out}, 16'h1);
  endtask : t_sleep
  task automatic t_pin_irq();
    int k;
    for (int p = 0; p < 2; p++) begin
      pins[p] <= 1'b1;
      await(irq, 1'b0, k);
      wr(pwrseq_pkg::REG_STATUS, 16'h001f);
      await(irq, 1'b1, k);
    end
  endtask : t_pin_irq
  task automatic t_power_off();
    int k;
    hold_req <= 1'b0;
    await(rst_out, 1'b0, k);
    await(core_a, 1'b0, k);
    check("all_off", {13'h0, core_b, io_on, gpo0}, 16'h0);
    wr(pwrseq_pkg::REG_STATUS, 16'h001f);
    wr(pwrseq_pkg::REG_CTRL, 16'h04f8);
    await(irq, 1'b0, k);
  endtask : t_power_off
  task automatic t_auto_keep();
    int k;
    hold_req <= 1'b0;
    await(core_a, 1'b0, k);
    wr(pwrseq_pkg::REG_STATUS, 16'h801f);
    wr(pwrseq_pkg::REG_MASK, 16'h0014);
    supply <= 1'b1;
    await(rst_out, 1'b1, k);
    supply <= 1'b0;
    rd(pwrseq_pkg::REG_CTRL);
    check("keep_auto", d, 16'h04b4);
    repeat (8 * SS) @(posedge clk_sys);
    shdn <= 1'b0;
    await(core_a, 1'b0, k);
    wr(pwrseq_pkg::REG_CTRL, 16'h05b4);
    shdn <= 1'b1;
    await(rst_out, 1'b1, k);
    repeat (8 * SS) @(posedge clk_sys);
    shdn <= 1'b0;
    await(core_b, 1'b0, k);
    check("rev_order", {15'h0, core_a}, 16'h0001);
    await(core_a, 1'b0, k);
    shdn <= 1'b1;
    await(rst_out, 1'b1, k);
    lp <= 1'b1;
    await(crst, 1'b1, k);
    await(core_a, 1'b0, k);
  endtask : t_auto_keep
  // ==========================================
  // Run control
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {rstn, reg_wr, reg_rd, hold_req, lp, supply, pins, reg_addr, reg_wdata} = '0;
    sleep_req = 1'b1;
    shdn      = 1'b1;
    {errors, total_checks, cyc} = '0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    t_defaults();
    t_power_on(16'h04b8, SL);
    t_sleep();
    t_pin_irq();
    t_power_off();
    t_power_on(16'h04b0, SS);
    t_auto_keep();
    conclude();
  end
endmodule : tb
